// ===== design/async_timer.sv
// Purpose: clock crossing, update paths, flags and wake-up of an 8-bit asynchronous timer
// Assumes: hclk more than four times the slow oscillator; one AHB-Lite master
// Notes: the timer logic runs on hclk, advanced every cycle in sync mode or by a tick enable from the oscillator in async mode
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "async_timer_map.svh"
module async_timer
    import async_timer_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic slow_osc_in,
    input wire logic cpu_sleeping,
    input wire logic compare_vector_ack,
    input wire logic overflow_vector_ack,
    output logic compare_irq_req,
    output logic overflow_irq_req,
    output logic wake_req,
    output logic cpu_halt,
    output logic compare_out
);
    // ==========================================================
    // declarations
    logic osc_sync;
    logic osc_prev_reg;
    logic osc_tick;
    logic timer_tick;
    logic async_clock_select_reg;
    logic global_irq_enable_reg;
    byte_t timer_irq_mask_reg;
    logic compare_match_flag_reg;
    logic overflow_flag_reg;
    byte_t counter_reg;
    byte_t count_copy_reg;
    logic count_down_reg;
    logic [`FLAG_SYNC_CYCLES-1:0] cmp_pipe_reg;
    logic [`FLAG_SYNC_CYCLES-1:0] ovf_pipe_reg;
    logic cmp_event;
    logic ovf_event;
    logic cmp_set;
    logic ovf_set;
    logic [7:0] wr_addr_reg;
    logic wr_pend_reg;
    logic addr_ok;
    logic wr_count;
    logic wr_compare;
    logic wr_control;
    byte_t wdata_byte;
    byte_t count_temp;
    byte_t count_dest;
    byte_t compare_temp;
    byte_t compare_dest;
    byte_t control_temp;
    byte_t control_dest;
    logic count_pending;
    logic compare_pending;
    logic control_pending;
    logic count_done;
    wake_state_e wake_state_reg;
    logic [2:0] halt_cnt_reg;
    logic irq_cond;
    byte_t read_mux;

    // ==========================================================
    // oscillator pin crossing and edge enable
    level_sync #(
        .WIDTH(1)
    ) osc_sync_u (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(slow_osc_in),
        .sync_out(osc_sync)
    );

    // edge detector reads the second stage only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_prev_reg <= 1'b0;
        end else begin
            osc_prev_reg <= osc_sync;
        end
    end

    assign osc_tick = osc_sync & ~osc_prev_reg;
    // timer clock source: hclk every cycle, or oscillator edges
    assign timer_tick = async_clock_select_reg ? osc_tick : 1'b1;

    // ==========================================================
    // AHB-Lite slave: zero wait, reads prepared in the address phase
    assign addr_ok = hsel & hready & htrans[1];
    assign wdata_byte = hwdata[7:0];
    assign wr_count = wr_pend_reg && (wr_addr_reg == `OFS_COUNTER_VALUE);
    assign wr_compare = wr_pend_reg && (wr_addr_reg == `OFS_COMPARE_VALUE);
    assign wr_control = wr_pend_reg && (wr_addr_reg == `OFS_TIMER_CONTROL);

    // read selection; unmapped offsets read zero
    always_comb begin
        read_mux = `RST_BYTE;
        unique case (haddr[7:0])
            `OFS_COUNTER_VALUE: read_mux = count_copy_reg;
            `OFS_COMPARE_VALUE: read_mux = compare_temp;
            `OFS_TIMER_CONTROL: read_mux = control_temp;
            `OFS_ASYNC_STATUS: read_mux = {4'h0, async_clock_select_reg, count_pending,
                                           compare_pending, control_pending};
            `OFS_IRQ_MASK: read_mux = timer_irq_mask_reg;
            `OFS_IRQ_FLAGS: read_mux = {6'h00, compare_match_flag_reg, overflow_flag_reg};
            `OFS_CORE_CTRL: read_mux = {7'h00, global_irq_enable_reg};
            default: read_mux = `RST_BYTE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0; // always OKAY
            wr_pend_reg <= addr_ok & hwrite;
            if (addr_ok) begin
                wr_addr_reg <= haddr[7:0];
            end
            if (addr_ok && !hwrite) begin
                hrdata <= {24'h000000, read_mux};
            end
        end
    end

    // plain control registers written in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            async_clock_select_reg <= 1'b0;
            timer_irq_mask_reg <= `RST_BYTE;
            global_irq_enable_reg <= 1'b0;
        end else if (wr_pend_reg) begin
            if (wr_addr_reg == `OFS_ASYNC_STATUS) begin
                async_clock_select_reg <= wdata_byte[`BIT_ASYNC_SELECT];
            end
            if (wr_addr_reg == `OFS_IRQ_MASK) begin
                timer_irq_mask_reg <= {6'h00, wdata_byte[`BIT_COMPARE], wdata_byte[`BIT_OVERFLOW]};
            end
            if (wr_addr_reg == `OFS_CORE_CTRL) begin
                global_irq_enable_reg <= wdata_byte[`BIT_CORE_IRQ_EN];
            end
        end
    end

    // ==========================================================
    // three independent temporary registers and transfers
    update_path #(
        .WIDTH(8)
    ) count_path_u (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_mode(async_clock_select_reg),
        .osc_tick(osc_tick),
        .wr_stb(wr_count),
        .wr_data(wdata_byte),
        .temp_reg(count_temp),
        .dest_reg(count_dest),
        .pending_reg(count_pending),
        .done_reg(count_done)
    );

    update_path #(
        .WIDTH(8)
    ) compare_path_u (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_mode(async_clock_select_reg),
        .osc_tick(osc_tick),
        .wr_stb(wr_compare),
        .wr_data(wdata_byte),
        .temp_reg(compare_temp),
        .dest_reg(compare_dest),
        .pending_reg(compare_pending),
        .done_reg()
    );

    update_path #(
        .WIDTH(8)
    ) control_path_u (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_mode(async_clock_select_reg),
        .osc_tick(osc_tick),
        .wr_stb(wr_control),
        .wr_data(wdata_byte),
        .temp_reg(control_temp),
        .dest_reg(control_dest),
        .pending_reg(control_pending),
        .done_reg()
    );

    // ==========================================================
    // counter; loads from the count path win over counting
    assign cmp_event = timer_tick && control_dest[`BIT_CTRL_RUN] && (counter_reg == compare_dest)
                       && !compare_pending && !count_pending && !count_done;
    assign ovf_event = timer_tick && control_dest[`BIT_CTRL_RUN] && !count_done &&
                       (control_dest[`BIT_CTRL_PWM] ? (count_down_reg && counter_reg == 8'h01)
                                                    : (counter_reg == 8'hFF));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            counter_reg <= `RST_BYTE;
            count_down_reg <= 1'b0;
        end else if (count_done) begin
            counter_reg <= count_dest;
        end else if (timer_tick && control_dest[`BIT_CTRL_RUN]) begin
            if (!control_dest[`BIT_CTRL_PWM]) begin
                counter_reg <= counter_reg + 8'h01;
                count_down_reg <= 1'b0;
            end else if (count_down_reg) begin
                counter_reg <= counter_reg - 8'h01;
                count_down_reg <= (counter_reg != 8'h01);
            end else begin
                counter_reg <= counter_reg + 8'h01;
                count_down_reg <= (counter_reg == 8'hFE);
            end
        end
    end

    // readable copy follows oscillator edges only in async mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_copy_reg <= `RST_BYTE;
        end else if (count_done) begin
            // the load lands a cycle after its edge; show it at once, not one period late
            count_copy_reg <= count_dest;
        end else if (!async_clock_select_reg || osc_tick) begin
            count_copy_reg <= counter_reg;
        end
    end

    // compare output pin moves on the timer tick, no extra crossing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_out <= 1'b0;
        end else if (cmp_event) begin
            unique case (control_dest[`BIT_CTRL_OUT_HI:`BIT_CTRL_OUT_LO])
                2'h1: compare_out <= ~compare_out;
                2'h2: compare_out <= count_down_reg;
                2'h3: compare_out <= ~count_down_reg;
                2'h0: compare_out <= compare_out;
            endcase
        end
    end

    // ==========================================================
    // flag synchronization pipeline: three hclk cycles in async mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_pipe_reg <= '0;
            ovf_pipe_reg <= '0;
        end else begin
            cmp_pipe_reg <= {cmp_pipe_reg[`FLAG_SYNC_CYCLES-2:0], cmp_event & async_clock_select_reg};
            ovf_pipe_reg <= {ovf_pipe_reg[`FLAG_SYNC_CYCLES-2:0], ovf_event & async_clock_select_reg};
        end
    end

    assign cmp_set = async_clock_select_reg ? cmp_pipe_reg[`FLAG_SYNC_CYCLES-1]
                                            : cmp_event;
    assign ovf_set = async_clock_select_reg ? ovf_pipe_reg[`FLAG_SYNC_CYCLES-1]
                                            : ovf_event;

    // sticky flags; a set in the clearing cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_match_flag_reg <= 1'b0;
            overflow_flag_reg <= 1'b0;
        end else begin
            if (cmp_set) begin
                compare_match_flag_reg <= 1'b1;
            end else if (compare_vector_ack || (wr_pend_reg && wr_addr_reg == `OFS_IRQ_FLAGS
                                                && wdata_byte[`BIT_COMPARE])) begin
                compare_match_flag_reg <= 1'b0;
            end
            if (ovf_set) begin
                overflow_flag_reg <= 1'b1;
            end else if (overflow_vector_ack || (wr_pend_reg && wr_addr_reg == `OFS_IRQ_FLAGS
                                                 && wdata_byte[`BIT_OVERFLOW])) begin
                overflow_flag_reg <= 1'b0;
            end
        end
    end

    // interrupt requests to the core
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_irq_req <= 1'b0;
            overflow_irq_req <= 1'b0;
        end else begin
            compare_irq_req <= compare_match_flag_reg & timer_irq_mask_reg[`BIT_COMPARE]
                               & global_irq_enable_reg;
            overflow_irq_req <= overflow_flag_reg & timer_irq_mask_reg[`BIT_OVERFLOW]
                                & global_irq_enable_reg;
        end
    end

    // ==========================================================
    // wake-up sequencing while the core sleeps
    assign irq_cond = global_irq_enable_reg &&
                      ((compare_match_flag_reg && timer_irq_mask_reg[`BIT_COMPARE]) ||
                       (overflow_flag_reg && timer_irq_mask_reg[`BIT_OVERFLOW]));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_state_reg <= WAKE_IDLE;
            wake_req <= 1'b0;
            cpu_halt <= 1'b0;
            halt_cnt_reg <= 3'h0;
        end else begin
            wake_req <= 1'b0;
            unique case (wake_state_reg)
                WAKE_IDLE: begin
                    if (cpu_sleeping && irq_cond) begin
                        wake_state_reg <= WAKE_WAIT_TICK;
                    end
                end
                WAKE_WAIT_TICK: begin
                    // wake starts on the next timer clock, so the count has advanced
                    if (timer_tick) begin
                        wake_req <= 1'b1;
                        cpu_halt <= 1'b1;
                        halt_cnt_reg <= 3'(`WAKE_HALT_CYCLES - 1);
                        wake_state_reg <= WAKE_HALT;
                    end
                end
                WAKE_HALT: begin
                    if (halt_cnt_reg == 3'h0) begin
                        cpu_halt <= 1'b0;
                        wake_state_reg <= WAKE_REARM;
                    end else begin
                        halt_cnt_reg <= halt_cnt_reg - 3'h1;
                    end
                end
                WAKE_REARM: begin
                    // a wake re-armed too early would be missed
                    if (timer_tick) begin
                        wake_state_reg <= WAKE_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// ===== design/async_timer_map.svh
// Purpose: offsets, field positions, reset values and timing counts of the async timer
// Assumes: 32-bit AHB-Lite word per register
// Notes: definitions only
`ifndef ASYNC_TIMER_MAP_SVH
`define ASYNC_TIMER_MAP_SVH
// ==========================================================
// register byte offsets
`define OFS_COUNTER_VALUE 8'h00
`define OFS_COMPARE_VALUE 8'h04
`define OFS_TIMER_CONTROL 8'h08
`define OFS_ASYNC_STATUS 8'h0C
`define OFS_IRQ_MASK 8'h10
`define OFS_IRQ_FLAGS 8'h14
`define OFS_CORE_CTRL 8'h18
// ==========================================================
// field positions
`define BIT_CONTROL_PENDING 0
`define BIT_COMPARE_PENDING 1
`define BIT_COUNT_PENDING 2
`define BIT_ASYNC_SELECT 3
`define BIT_OVERFLOW 0
`define BIT_COMPARE 1
`define BIT_CTRL_RUN 0
`define BIT_CTRL_PWM 1
`define BIT_CTRL_OUT_LO 4
`define BIT_CTRL_OUT_HI 5
`define BIT_CORE_IRQ_EN 0
// ==========================================================
// reset values and timing counts
`define RST_BYTE 8'h00
`define XFER_EDGES 2
`define FLAG_SYNC_CYCLES 3
`define WAKE_HALT_CYCLES 4
`endif

// ===== design/async_timer_pkg.sv
// Purpose: shared types of the async timer
// Assumes: nothing
// Notes: constants live in the map header
package async_timer_pkg;
    typedef enum logic [1:0] {WAKE_IDLE, WAKE_WAIT_TICK, WAKE_HALT, WAKE_REARM} wake_state_e;
    typedef logic [7:0] byte_t;
endpackage

// ===== design/level_sync.sv
// Purpose: two flip-flop synchroniser for levels from outside the clock domain
// Assumes: input is a slow level
// Notes: first stage read only by the second
`timescale 1ns/1ns
module level_sync #(
    parameter int WIDTH = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_reg;

    initial begin
        if (WIDTH < 1) $error("level_sync: WIDTH must be at least 1");
    end

    // ==========================================================
    // two stages
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage_reg <= '0;
            sync_out <= '0;
        end else begin
            stage_reg <= async_in;
            sync_out <= stage_reg;
        end
    end
endmodule

// ===== design/update_path.sv
// Purpose: temporary register and transfer into the timer domain for one register
// Assumes: osc_tick is a one-cycle pulse per rising slow oscillator edge
// Notes: synchronous mode transfers on the next cycle with no busy flag
`timescale 1ns/1ns
`include "async_timer_map.svh"
module update_path #(
    parameter int WIDTH = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic async_mode,
    input wire logic osc_tick,
    input wire logic wr_stb,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [WIDTH-1:0] temp_reg,
    output logic [WIDTH-1:0] dest_reg,
    output logic pending_reg,
    output logic done_reg
);
    logic [1:0] edge_cnt_reg;
    logic sync_load_reg;

    initial begin
        if (WIDTH < 1) $error("update_path: WIDTH must be at least 1");
    end

    // ==========================================================
    // capture into the temporary register, count edges, then latch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            temp_reg <= '0;
            dest_reg <= '0;
            pending_reg <= 1'b0;
            done_reg <= 1'b0;
            edge_cnt_reg <= 2'h0;
            sync_load_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            sync_load_reg <= 1'b0;
            if (wr_stb) begin
                temp_reg <= wr_data;
                edge_cnt_reg <= 2'h0;
                pending_reg <= async_mode;
                sync_load_reg <= ~async_mode;
            end else if (pending_reg && osc_tick) begin
                // a write here restarts only this path, never a sibling
                if (edge_cnt_reg == 2'(`XFER_EDGES - 1)) begin
                    dest_reg <= temp_reg;
                    pending_reg <= 1'b0;
                    done_reg <= 1'b1;
                end else begin
                    edge_cnt_reg <= edge_cnt_reg + 2'h1;
                end
            end else if (sync_load_reg) begin
                dest_reg <= temp_reg;
                done_reg <= 1'b1;
            end
        end
    end
endmodule

// ===== test/async_timer_chk.sv
// Purpose: port assertions of the async timer
// Assumes: bound to async_timer; one clock domain
// Notes: oscillator rises are detected again here to time the outputs
`timescale 1ns/1ns
module async_timer_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic slow_osc_in,
    input wire logic compare_vector_ack,
    input wire logic overflow_vector_ack,
    input wire logic compare_irq_req,
    input wire logic overflow_irq_req,
    input wire logic wake_req,
    input wire logic cpu_halt,
    input wire logic compare_out
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [1:0] osc_s_reg;
    logic [7:0] since_reg;
    logic [1:0] rises_reg;
    logic rise;
    assign rise = osc_s_reg == 2'h1;
    // ==========================================================
    // oscillator timing
    // cycles since the last rise, saturating so it never wraps into range
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_s_reg <= 2'h0;
            since_reg <= 8'hFF;
        end else begin
            osc_s_reg <= {osc_s_reg[0], slow_osc_in};
            since_reg <= rise ? 8'h00 : since_reg + {7'h0, since_reg != 8'hFF};
        end
    end
    // rises since the last wake, never fewer than the ticks the design saw
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) rises_reg <= 2'h3;
        else if (wake_req) rises_reg <= 2'h0;
        else if (rise && rises_reg != 2'h3) rises_reg <= rises_reg + 2'h1;
    end
    // ==========================================================
    // assertions
    sequence halt_run;
        cpu_halt [*4] ##1 !cpu_halt;
    endsequence
    a_halt_four_cycles: assert property (wake_req |-> halt_run)
        else $error("halt length wrong");
    a_halt_needs_wake: assert property ($rose(cpu_halt) |-> wake_req)
        else $error("halt without wake");
    a_wake_one_cycle: assert property (wake_req |=> !wake_req)
        else $error("wake pulse too long");
    a_wake_on_tick: assert property (wake_req |-> since_reg <= 8'h08)
        else $error("wake away from oscillator edge");
    a_wake_rearm_tick: assert property (wake_req |-> rises_reg >= 2'h2)
        else $error("wake before rearm tick");
    a_out_on_tick: assert property ($changed(compare_out) |-> since_reg <= 8'h08)
        else $error("compare pin moved off tick");
    a_cmp_ack_clears: assert property (compare_vector_ack |-> ##[1:3] !compare_irq_req)
        else $error("compare request stuck");
    a_ovf_ack_clears: assert property (overflow_vector_ack |-> ##[1:3] !overflow_irq_req)
        else $error("overflow request stuck");
endmodule

// ===== test/async_timer_sync_and_irq_bench.sv
// Purpose: self-checking bench of the async timer crossing and interrupts
// Assumes: hclk 20 MHz; oscillator from slow_osc_model
// Notes: each scenario task drives the bus and judges its own results
`timescale 1ns/1ns
`include "async_timer_map.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module async_timer_sync_and_irq_bench import async_timer_pkg::*;;
    logic hclk, hresetn, hsel, hwrite, osc_run, cpu_sleeping, compare_vector_ack, overflow_vector_ack;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, slow_osc_in, compare_irq_req, overflow_irq_req, wake_req, cpu_halt, compare_out;
    int fails, check_count, cyc;
    // ==========================================================
    // clock and instances
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    always @(posedge hclk) cyc <= cyc + 1;
    slow_osc_model osc (.run(osc_run), .slow_osc_in(slow_osc_in));
    async_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .slow_osc_in(slow_osc_in), .cpu_sleeping(cpu_sleeping),
        .compare_vector_ack(compare_vector_ack), .overflow_vector_ack(overflow_vector_ack),
        .compare_irq_req(compare_irq_req), .overflow_irq_req(overflow_irq_req), .wake_req(wake_req),
        .cpu_halt(cpu_halt), .compare_out(compare_out));
    // ==========================================================
    // bus and wait tasks
    task automatic end_of_test();
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic die();
        fails++;
        end_of_test();
    endtask
    // hready is sampled at the edge; a stuck slave ends the run
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 40) die();
            @(posedge hclk);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input byte_t d, output byte_t q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy();
        q = hrdata[7:0];
    endtask
    task automatic wr(input logic [7:0] a, input byte_t d);
        byte_t q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input byte_t e);
        byte_t q;
        bus(1'b0, a, 8'h00, q);
        `CHK(q, e)
    endtask
    // bounded so that a dead timer cannot hang the run
    task automatic wait_for(input int which, input int lim);
        int n;
        n = 0;
        while ((which == 0 ? overflow_irq_req : which == 1 ? compare_irq_req : wake_req) !== 1'b1) begin
            n++;
            if (n > lim) die();
            @(posedge hclk);
        end
    endtask
    task automatic wait_idle();
        byte_t q;
        int t0;
        t0 = cyc;
        q = 8'h07;
        while (q[2:0] !== 3'h0) begin
            if (cyc - t0 > 200) die();
            bus(1'b0, `OFS_ASYNC_STATUS, 8'h00, q);
        end
    endtask
    // ==========================================================
    // scenarios
    // reset values, read-only busy bits, unmapped word, sync-mode write
    task automatic t_regs();
        rd_chk(`OFS_IRQ_MASK, 8'h00);
        rd_chk(`OFS_IRQ_FLAGS, 8'h00);
        wr(8'h1C, 8'hFF);
        rd_chk(8'h1C, 8'h00);
        wr(`OFS_COMPARE_VALUE, 8'h5A);
        rd_chk(`OFS_ASYNC_STATUS, 8'h00);
        rd_chk(`OFS_COMPARE_VALUE, 8'h5A);
        wr(`OFS_ASYNC_STATUS, 8'h0F);
        rd_chk(`OFS_ASYNC_STATUS, 8'h08);
    endtask
    // three writes back to back; each keeps its own busy bit for two edges
    task automatic t_async();
        int t0;
        osc_run <= 1'b1;
        wr(`OFS_COMPARE_VALUE, 8'h40);
        wr(`OFS_TIMER_CONTROL, 8'h10);
        t0 = cyc;
        wr(`OFS_COUNTER_VALUE, 8'h10);
        rd_chk(`OFS_ASYNC_STATUS, 8'h0F);
        rd_chk(`OFS_COMPARE_VALUE, 8'h40);
        rd_chk(`OFS_TIMER_CONTROL, 8'h10);
        wait_idle();
        `CHK(cyc - t0 >= 23 && cyc - t0 < 60, 1'b1)
        rd_chk(`OFS_COUNTER_VALUE, 8'h10);
    endtask
    // wrap from 0xFF raises the overflow flag; the vector clears it
    task automatic t_ovf();
        wr(`OFS_COUNTER_VALUE, 8'hFE);
        wr(`OFS_TIMER_CONTROL, 8'h11);
        wr(`OFS_IRQ_MASK, 8'h01);
        wr(`OFS_CORE_CTRL, 8'h01);
        wait_for(0, 400);
        rd_chk(`OFS_IRQ_FLAGS, 8'h01);
        overflow_vector_ack <= 1'b1;
        @(posedge hclk);
        overflow_vector_ack <= 1'b0;
        rd_chk(`OFS_IRQ_FLAGS, 8'h00);
    endtask
    // match toggles the pin; request needs the global enable
    task automatic t_cmp();
        wr(`OFS_COMPARE_VALUE, 8'h20);
        wr(`OFS_IRQ_MASK, 8'h02);
        wait_for(1, 1500);
        `CHK(compare_out, 1'b1)
        rd_chk(`OFS_IRQ_FLAGS, 8'h02);
        wr(`OFS_CORE_CTRL, 8'h00);
        repeat (2) @(posedge hclk);
        `CHK(compare_irq_req, 1'b0)
        wr(`OFS_IRQ_FLAGS, 8'h02);
        rd_chk(`OFS_IRQ_FLAGS, 8'h00);
        wr(`OFS_CORE_CTRL, 8'h01);
    endtask
    // sleeping core woken by the next match, then halted four cycles
    task automatic t_wake();
        int n;
        n = 0;
        wait_idle();
        cpu_sleeping <= 1'b1;
        wait_for(2, 8000);
        while (cpu_halt === 1'b1 && n < 9) begin
            n++;
            @(posedge hclk);
        end
        `CHK(n, 4)
        cpu_sleeping <= 1'b0;
        compare_vector_ack <= 1'b1;
        @(posedge hclk);
        compare_vector_ack <= 1'b0;
        rd_chk(`OFS_IRQ_FLAGS, 8'h01);
    endtask
    // mid-run reset: the status and compare registers are lost and read their reset values
    task automatic t_reset();
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(`OFS_ASYNC_STATUS, 8'h00);
        rd_chk(`OFS_COMPARE_VALUE, 8'h00);
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        osc_run = 1'b0;
        cpu_sleeping = 1'b0;
        compare_vector_ack = 1'b0;
        overflow_vector_ack = 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_async();
        t_ovf();
        t_cmp();
        t_wake();
        t_reset();
        end_of_test();
    end
endmodule
bind async_timer async_timer_chk chk (.hclk(hclk), .hresetn(hresetn), .slow_osc_in(slow_osc_in),
    .compare_vector_ack(compare_vector_ack), .overflow_vector_ack(overflow_vector_ack),
    .compare_irq_req(compare_irq_req), .overflow_irq_req(overflow_irq_req), .wake_req(wake_req),
    .cpu_halt(cpu_halt), .compare_out(compare_out));

// ===== test/slow_osc_model.sv
// Purpose: slow oscillator partner driving the timer oscillator pin
// Assumes: period far above four hclk periods
// Notes: pin rests low while stopped, as a halted crystal does
`timescale 1ns/1ns
module slow_osc_model #(
    parameter int HALF_NS = 585
) (
    input wire logic run,
    output logic slow_osc_in
);
    // ==========================================================
    // oscillator
    // start offset off the 5 ns grid keeps every edge off the hclk edges
    always begin
        if (run) begin
            #HALF_NS slow_osc_in = ~slow_osc_in;
        end else begin
            slow_osc_in = 1'b0;
            @(run);
            #7;
        end
    end
endmodule
